// [design/bsw_status_window.sv]
/*
  Secondary status flags and non-prefetchable memory window of a bridge
  port, with a small interrupt wrapper around the sticky flags.
  Assumes a single-cycle register port on mclk, events as one-cycle
  pulses synchronous to mclk, and a synchronous active-low reset.
  Assumes the two bridge control enables are held here as a narrow
  stand-in for the full bridge control register, and that a request
  address matters only while its valid bit is high.
*/
// Local design decision: the address-and-strobe port.
// Summary of operation
// R1: the master data parity error flag never sets while parity error response is off.
// R2: with parity response on, a poisoned completion received or poisoned write sent sets it.
// R3: the received system error flag never sets while system error enable is off.
// R4: with system error enable on, a fatal or non-fatal error message sets that flag.
// R5: any poisoned packet received on the secondary side sets the detected parity flag.
// R6: status bits 7:0, 10:9 and 13:11 read zero and ignore writes.
// R7: the window base holds address bits 31:20 in bits 15:4, resets to all ones, 3:0 read zero.
// R8: the window limit holds address bits 31:20 in bits 15:4, resets to zero, 3:0 read zero.
// R9: base and limit steer forwarding of non-prefetchable memory requests.
// R10: writing one to a status flag clears it, writing zero leaves it.
// R11: an address between base and limit inclusive is forwarded; base above limit forwards none.
`include "bsw_params.svh"

module bsw_status_window (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // secondary-side events
  input wire bsw_pkg::bsw_evt_s secEvt,
  // memory request and forwarding decision
  input wire bsw_pkg::bsw_req_s memReq,
  output bsw_pkg::bsw_fwd_s memFwd,
  // interrupt
  output logic irq
);

  // only these three status bits have storage; every other position
  // reads zero and ignores writes with no flip-flop behind it
  localparam bsw_pkg::bsw_word_t FlagMask = bsw_pkg::bsw_word_t'(
    (16'h1 << `BSW_BIT_MDP) | (16'h1 << `BSW_BIT_RXSYS) | (16'h1 << `BSW_BIT_DETPAR));

  // register state and next values
  bsw_pkg::bsw_word_t statusReg;
  bsw_pkg::bsw_word_t statusNext;
  bsw_pkg::bsw_word_t maskReg;
  bsw_pkg::bsw_word_t maskNext;
  logic [1:0] ctrlReg;
  logic [1:0] ctrlNext;
  logic [11:0] baseReg;
  logic [11:0] baseNext;
  logic [11:0] limitReg;
  logic [11:0] limitNext;

  // read data and forwarding registers
  bsw_pkg::bsw_word_t rdataReg;
  bsw_pkg::bsw_word_t rdataNext;
  bsw_pkg::bsw_fwd_s fwdReg;
  bsw_pkg::bsw_fwd_s fwdNext;

  // decoded terms
  bsw_pkg::bsw_word_t flagSet;
  bsw_pkg::bsw_word_t flagClr;
  logic perrEn;
  logic serrEn;
  logic [11:0] reqPage;

  assign perrEn = ctrlReg[`BSW_BIT_PERR_EN];
  assign serrEn = ctrlReg[`BSW_BIT_SERR_EN];
  assign reqPage = memReq.addr[`BSW_ADDR_MSB:`BSW_ADDR_LSB];

  // hardware set terms, the first two gated by the bridge control enables
  always_comb begin
    flagSet = `BSW_RST_WORD;
    flagSet[`BSW_BIT_MDP] = perrEn & (secEvt.poisonCplRx | secEvt.poisonWrTx); // R1 R2
    flagSet[`BSW_BIT_RXSYS] = serrEn & (secEvt.errFatalRx | secEvt.errNonfatalRx); // R3 R4
    flagSet[`BSW_BIT_DETPAR] = secEvt.poisonTlpRx; // R5
  end

  // write-one-to-clear; reserved positions are masked out
  always_comb begin
    flagClr = `BSW_RST_WORD;
    if (regWr && regAddr == `BSW_OFS_SEC_STATUS) begin
      flagClr = regWdata & FlagMask; // R10 R6
    end
  end

  // status next value: a set in the same cycle as a clear wins
  always_comb begin
    statusNext = ((statusReg & ~flagClr) | flagSet) & FlagMask; // R10 R6
  end

  // configuration writes: window, control and interrupt mask
  always_comb begin
    baseNext = baseReg;
    limitNext = limitReg;
    ctrlNext = ctrlReg;
    maskNext = maskReg;
    if (regWr) begin
      if (regAddr == `BSW_OFS_WIN_BASE) begin
        baseNext = regWdata[`BSW_WIN_MSB:`BSW_WIN_LSB]; // R7
      end else if (regAddr == `BSW_OFS_WIN_LIMIT) begin
        limitNext = regWdata[`BSW_WIN_MSB:`BSW_WIN_LSB]; // R8
      end else if (regAddr == `BSW_OFS_BRIDGE_CTRL) begin
        ctrlNext = regWdata[1:0];
      end else if (regAddr == `BSW_OFS_IRQ_MASK) begin
        maskNext = regWdata & FlagMask;
      end
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdataNext = `BSW_RST_WORD;
    if (regRd) begin
      if (regAddr == `BSW_OFS_SEC_STATUS) begin
        rdataNext = statusReg; // R6
      end else if (regAddr == `BSW_OFS_WIN_BASE) begin
        rdataNext = {baseReg, 4'h0}; // R7
      end else if (regAddr == `BSW_OFS_WIN_LIMIT) begin
        rdataNext = {limitReg, 4'h0}; // R8
      end else if (regAddr == `BSW_OFS_BRIDGE_CTRL) begin
        rdataNext = {14'h0, ctrlReg};
      end else if (regAddr == `BSW_OFS_IRQ_MASK) begin
        rdataNext = maskReg;
      end
    end
  end

  // window decode; limit's low twenty bits count as all ones, so a page
  // compare is exact, and base above limit can never match
  always_comb begin
    fwdNext.valid = memReq.valid; // R9
    fwdNext.hit = memReq.valid && (reqPage >= baseReg) && (reqPage <= limitReg); // R11
  end

  // sticky status register; reset clears every flag so no stale error
  // survives a configuration reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      statusReg <= `BSW_RST_WORD;
    end else begin
      statusReg <= statusNext; // R10
    end
  end

  // configuration registers; base resets high and limit low, so the
  // window starts empty and nothing is forwarded before software sets it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      maskReg <= `BSW_RST_WORD;
      ctrlReg <= `BSW_RST_CTRL;
      baseReg <= `BSW_RST_WIN_BASE; // R7
      limitReg <= `BSW_RST_WIN_LIMIT; // R8
    end else begin
      maskReg <= maskNext;
      ctrlReg <= ctrlNext;
      baseReg <= baseNext;
      limitReg <= limitNext;
    end
  end

  // read data register; zero outside the answer cycle, so the data of
  // several slaves could be merged by a plain OR
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdataReg <= `BSW_RST_WORD;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  // forwarding decision register; one cycle of latency buys a clean
  // timing path from the compare to the logic that reads memFwd
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fwdReg <= '0;
    end else begin
      fwdReg <= fwdNext;
    end
  end

  // outputs; irq is a level from registers, so it cannot glitch, and
  // masking a flag hides it from irq but not from a status read
  assign regRdata = rdataReg;
  assign memFwd = fwdReg;
  assign irq = |(statusReg & maskReg);

  // checks; all are off while reset is low, so reset values are
  // checked on the first edge after release
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  mdp_gated_a: assert property ( // R1
    (!perrEn && !statusReg[`BSW_BIT_MDP]) |=> !statusReg[`BSW_BIT_MDP])
    else $error("parity flag set while response disabled");

  mdp_set_a: assert property ( // R2
    (perrEn && (secEvt.poisonCplRx || secEvt.poisonWrTx)) |=> statusReg[`BSW_BIT_MDP])
    else $error("parity flag missed a poisoned transfer");

  rxsys_gated_a: assert property ( // R3
    (!serrEn && !statusReg[`BSW_BIT_RXSYS]) |=> !statusReg[`BSW_BIT_RXSYS])
    else $error("system error flag set while enable cleared");

  rxsys_set_a: assert property ( // R4
    (serrEn && (secEvt.errFatalRx || secEvt.errNonfatalRx))
    |=> statusReg[`BSW_BIT_RXSYS])
    else $error("system error flag missed an error message");

  detpar_set_a: assert property ( // R5
    secEvt.poisonTlpRx |=> statusReg[`BSW_BIT_DETPAR])
    else $error("detected parity flag missed a poisoned packet");

  status_rsvd_a: assert property ( // R6
    (regRd && regAddr == `BSW_OFS_SEC_STATUS) |=> ((regRdata & ~FlagMask) == 16'h0000))
    else $error("reserved status bits read nonzero");

  base_write_read_a: assert property ( // R7
    (regWr && regAddr == `BSW_OFS_WIN_BASE) ##1 (regRd && regAddr == `BSW_OFS_WIN_BASE)
    |=> (regRdata == {$past(regWdata[15:4], 2), 4'h0}))
    else $error("window base readback mismatch");

  limit_write_read_a: assert property ( // R8
    (regWr && regAddr == `BSW_OFS_WIN_LIMIT) ##1 (regRd && regAddr == `BSW_OFS_WIN_LIMIT)
    |=> (regRdata == {$past(regWdata[15:4], 2), 4'h0}))
    else $error("window limit readback mismatch");

  window_fwd_a: assert property ( // R9 R11
    memReq.valid |=> (memFwd.valid && memFwd.hit ==
      ($past(reqPage) >= $past(baseReg) && $past(reqPage) <= $past(limitReg))))
    else $error("forwarding decision disagrees with window");

  flag_clear_a: assert property ( // R10
    (regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_DETPAR]
      && !secEvt.poisonTlpRx) |=> !statusReg[`BSW_BIT_DETPAR])
    else $error("write of one did not clear detected parity flag");

  rdata_idle_a: assert property (
    !regRd |=> (regRdata == 16'h0000))
    else $error("read data outside the answer cycle");

  reset_values_a: assert property ( // R7 R8
    $rose(resetn) |-> (baseReg == `BSW_RST_WIN_BASE && limitReg == `BSW_RST_WIN_LIMIT))
    else $error("window registers not at reset values");

  window_low_zero_a: assert property ( // R7 R8
    (regRd && (regAddr == `BSW_OFS_WIN_BASE || regAddr == `BSW_OFS_WIN_LIMIT))
    |=> (regRdata[3:0] == 4'h0))
    else $error("window register low bits read nonzero");

  mdp_clear_a: assert property ( // R10
    (regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_MDP]
      && !(perrEn && (secEvt.poisonCplRx || secEvt.poisonWrTx)))
    |=> !statusReg[`BSW_BIT_MDP])
    else $error("write of one did not clear parity flag");

  rxsys_clear_a: assert property ( // R10
    (regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_RXSYS]
      && !(serrEn && (secEvt.errFatalRx || secEvt.errNonfatalRx)))
    |=> !statusReg[`BSW_BIT_RXSYS])
    else $error("write of one did not clear system error flag");

  mdp_hold_a: assert property ( // R10
    (statusReg[`BSW_BIT_MDP]
      && !(regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_MDP]))
    |=> statusReg[`BSW_BIT_MDP])
    else $error("parity flag dropped without a clear");

  rxsys_hold_a: assert property ( // R10
    (statusReg[`BSW_BIT_RXSYS]
      && !(regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_RXSYS]))
    |=> statusReg[`BSW_BIT_RXSYS])
    else $error("system error flag dropped without a clear");

  detpar_hold_a: assert property ( // R10
    (statusReg[`BSW_BIT_DETPAR]
      && !(regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_DETPAR]))
    |=> statusReg[`BSW_BIT_DETPAR])
    else $error("detected parity flag dropped without a clear");

  fwd_idle_a: assert property ( // R9
    !memReq.valid |=> (memFwd == '0))
    else $error("forwarding decision without a request");

  empty_window_a: assert property ( // R11
    (memReq.valid && baseReg > limitReg) |=> !memFwd.hit)
    else $error("request forwarded through an empty window");

  mask_rsvd_a: assert property (
    (regRd && regAddr == `BSW_OFS_IRQ_MASK) |=> ((regRdata & ~FlagMask) == 16'h0000))
    else $error("reserved mask bits read nonzero");

  // main scenarios
  fwd_hit_c: cover property (memReq.valid ##1 memFwd.hit);
  irq_rise_c: cover property (!irq ##1 irq);
  set_clear_race_c: cover property (
    regWr && regAddr == `BSW_OFS_SEC_STATUS && regWdata[`BSW_BIT_DETPAR]
    && secEvt.poisonTlpRx);
  empty_window_c: cover property (baseReg > limitReg && memReq.valid);
  flag_clear_c: cover property (statusReg[`BSW_BIT_MDP] ##1 !statusReg[`BSW_BIT_MDP]);

endmodule : bsw_status_window

// [design/bsw_params.svh]
/*
  Offsets, field positions and reset values of the bridge secondary status
  and non-prefetchable memory window registers.
  Assumes byte offsets on a 12-bit configuration address and 16-bit data.
*/
`ifndef BSW_PARAMS_SVH
`define BSW_PARAMS_SVH

// register byte offsets
`define BSW_OFS_SEC_STATUS 12'h01E
`define BSW_OFS_WIN_BASE 12'h020
`define BSW_OFS_WIN_LIMIT 12'h022
`define BSW_OFS_BRIDGE_CTRL 12'h03E
`define BSW_OFS_IRQ_MASK 12'h040

// sticky flag positions in the secondary status register
`define BSW_BIT_MDP 8
`define BSW_BIT_RXSYS 14
`define BSW_BIT_DETPAR 15

// enable positions in the bridge control register
`define BSW_BIT_PERR_EN 0
`define BSW_BIT_SERR_EN 1

// window field position inside base and limit
`define BSW_WIN_LSB 4
`define BSW_WIN_MSB 15
`define BSW_ADDR_LSB 20
`define BSW_ADDR_MSB 31

// reset values
`define BSW_RST_WIN_BASE 12'hFFF
`define BSW_RST_WIN_LIMIT 12'h000
`define BSW_RST_WORD 16'h0000
`define BSW_RST_CTRL 2'h0

`endif

// [design/bsw_pkg.sv]
/*
  Types shared by the bridge secondary status and memory window block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bsw_pkg;

  // 16-bit configuration register word
  typedef logic [15:0] bsw_word_t;

  // secondary-side events, each a one-cycle pulse
  typedef struct packed {
    logic poisonCplRx;
    logic poisonWrTx;
    logic poisonTlpRx;
    logic errFatalRx;
    logic errNonfatalRx;
  } bsw_evt_s;

  // non-prefetchable memory request seen on the primary side
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } bsw_req_s;

  // forwarding decision, one cycle after the request
  typedef struct packed {
    logic valid;
    logic hit;
  } bsw_fwd_s;

endpackage : bsw_pkg

// [verif/bsw_sec_link.sv]
/*
  Behavioural secondary side: turns a bench command into event pulses.
  Assumes the bench holds go for exactly one mclk cycle per event burst.
*/
module bsw_sec_link (
  // command from the bench
  input wire logic go,
  input wire logic [4:0] kind,
  // event pulses toward the bridge
  output bsw_pkg::bsw_evt_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulses only while go is high, so no stale event lingers between bursts
  assign evt = go ? bsw_pkg::bsw_evt_s'(kind) : bsw_pkg::bsw_evt_s'(5'h00);
endmodule : bsw_sec_link

// [verif/tb_bsw_status_window.sv]
/*
  Bench for the bridge status and window block: register table, sticky
  flags, interrupt and window decisions.
  Assumes the design files compile first; one clock, no random values.
*/
module tb_bsw_status_window;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, regWr, regRd, go, irq;
  logic [11:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [4:0] kind;
  bsw_pkg::bsw_evt_s secEvt;
  bsw_pkg::bsw_req_s memReq;
  bsw_pkg::bsw_fwd_s memFwd;
  int fail_count, check_count;
  // address, write data, value after reset, value read back after the write
  typedef struct {logic [11:0] a; logic [15:0] w, r, e;} bsw_row_s;
  bsw_row_s rows[6] = '{
    '{12'h01E, 16'hFFFF, 16'h0000, 16'h0000},
    '{12'h020, 16'hA5A5, 16'hFFF0, 16'hA5A0},
    '{12'h022, 16'hFFFF, 16'h0000, 16'hFFF0},
    '{12'h03E, 16'hFFFF, 16'h0000, 16'h0003},
    '{12'h040, 16'hFFFF, 16'h0000, 16'hC100},
    '{12'h100, 16'hFFFF, 16'h0000, 16'h0000}};

  bsw_sec_link link (.go(go), .kind(kind), .evt(secEvt));
  bsw_status_window uut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .secEvt(secEvt), .memReq(memReq), .memFwd(memFwd), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk("regRdata", regRdata, e);
  endtask : rd

  // write then read with no idle cycle between the two strobes
  task wrrd(input logic [11:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk("regRdata", regRdata, e);
  endtask : wrrd

  task fire(input logic [4:0] k);
    @(posedge mclk);
    go <= 1'b1;
    kind <= k;
    @(posedge mclk);
    go <= 1'b0;
    #1;
  endtask : fire

  task req(input logic [31:0] a, input logic h);
    @(posedge mclk);
    memReq <= '{valid: 1'b1, addr: a};
    @(posedge mclk);
    memReq <= '0;
    #1 chk("memFwd", {14'h0, memFwd}, {14'h0, 1'b1, h});
  endtask : req

  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    resetn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    go = 1'b0;
    kind = 5'h00;
    regAddr = 12'h000;
    regWdata = 16'h0000;
    memReq = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1 chk("irq", {15'h0, irq}, 16'h0000);
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].r);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    // both enables off: only the detected parity flag may set
    wr(12'h03E, 16'h0000);
    fire(5'h1F);
    rd(12'h01E, 16'h8000);
    chk("irq", {15'h0, irq}, 16'h0001);
    wr(12'h01E, 16'h0000);
    rd(12'h01E, 16'h8000);
    wr(12'h01E, 16'h8000);
    rd(12'h01E, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    $display("test enables off done");
    // enables on: poisoned write sent, then a fatal message
    wr(12'h03E, 16'h0003);
    fire(5'h08);
    rd(12'h01E, 16'h0100);
    fire(5'h02);
    rd(12'h01E, 16'h4100);
    wr(12'h01E, 16'hFFFF);
    fire(5'h15);
    rd(12'h01E, 16'hC100);
    wr(12'h040, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    $display("test enables on done");
    // a poisoned packet in the cycle that clears all flags: its set wins
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= 12'h01E;
    regWdata <= 16'hC100;
    go <= 1'b1;
    kind <= 5'h04;
    @(posedge mclk);
    regWr <= 1'b0;
    go <= 1'b0;
    rd(12'h01E, 16'h8000);
    $display("test set and clear race done");
    // window edges, inclusive at both ends
    wrrd(12'h020, 16'h001F, 16'h0010);
    wrrd(12'h022, 16'h002C, 16'h0020);
    req(32'h000F_FFFF, 1'b0);
    req(32'h0010_0000, 1'b1);
    @(posedge mclk);
    #1 chk("memFwd", {14'h0, memFwd}, 16'h0000);
    req(32'h002F_FFFF, 1'b1);
    req(32'h0030_0000, 1'b0);
    wr(12'h020, 16'h0030);
    req(32'h0020_0000, 1'b0);
    $display("test window done");
    // second reset in mid-run restores the base
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    rd(12'h020, 16'hFFF0);
    rd(12'h01E, 16'h0000);
    rd(12'h022, 16'h0000);
    $display("test second reset done");
    close_out;
  end

  // the tests need about 115 cycles; this is far beyond that
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule : tb_bsw_status_window
